/* File: core_decode_defs.svh */
/*
 * Constants for the instruction decode and timing block: phase count,
 * field positions, opcode patterns and reset values.
 * Assumes inclusion by bare name, with no other definitions depending on it.
 */
`ifndef CORE_DECODE_DEFS_SVH
`define CORE_DECODE_DEFS_SVH

// ============================================================
// Timing
`define PHASES_PER_CYCLE 3'h4
`define PHASE_LAST       2'h3

// ============================================================
// Field positions
`define F_ADDR_HI        6
`define D_BIT_POS        7
`define B_NUM_LO         7
`define B_NUM_HI         9
`define FILE_ADDR_MAX    7'h7f

// ============================================================
// Reset values
`define WREG_RESET       8'h00
`define IWORD_RESET      14'h0000
`define NOP_WORD         14'h0000

// ============================================================
// Opcode patterns
`define OP_OR_PAT         6'h04
`define OP_SHL_PAT        6'h35
`define OP_SHR_PAT        6'h36
`define OP_DEC_SKIP_PAT   6'h0b
`define OP_INC_SKIP_PAT   6'h0f
`define OP_BITSKIP_CLR    4'h6
`define OP_BITSKIP_SET    4'h7
`define OP_CALL_TOP       3'h4
`define OP_JUMP_TOP       3'h5
`define OP_REL_JUMP_TOP   5'h19
`define OP_RETURN_WORD    14'h0008
`define OP_INT_EXIT_WORD  14'h0009
`define OP_CALC_CALL_WORD 14'h000a
`define OP_OFS_JUMP_WORD  14'h000b
`define OP_LIT_EXIT_TOP   6'h34

`endif

/* File: core_decode_pkg.sv */
/*
 * Types for the instruction decode and timing block.
 * Encodings are given here directly; nothing is taken from core_decode_defs.svh.
 */
package core_decode_pkg;

    // ============================================================
    // Format groups
    typedef enum logic [1:0] {
        fmt_byte    = 2'h0,
        fmt_bit     = 2'h1,
        fmt_literal = 2'h2
    } fmt_t;

    // ============================================================
    // Sequencer states
    typedef enum logic [2:0] {
        st_fetch = 3'h1,
        st_exec  = 3'h2,
        st_extra = 3'h4
    } seq_t;

endpackage

/* File: core_instruction_timing_decode.sv */
/*
 * Instruction decode and execution timing for an 8-bit core.
 * Holds the phase counter, cycle count per instruction, the file operand
 * read-modify-write handshake and the OR / left shift ALU paths.
 * Assumes program memory presents a word in the cycle that fetch_req is seen,
 * and the file register array answers a read combinationally.
 */
`timescale 1ns/10ps
`include "core_decode_defs.svh"

module core_instruction_timing_decode (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Program memory
    input  wire logic [13:0] prog_word,
    output logic             fetch_req,
    // File register array
    output logic [6:0]       file_addr,
    output logic             file_rd,
    input  wire logic [7:0]  file_rdata,
    output logic             file_wr,
    output logic [7:0]       file_wdata,
    // Indirect access status
    input  wire logic        indirect_sel,
    input  wire logic        ptr_in_prog,
    // Status and decode view
    input  wire logic        carry_in,
    output logic             zero_flag,
    output logic             carry_flag,
    output logic             status_wr,
    output logic [7:0]       wreg,
    output logic [1:0]       fmt,
    output logic [2:0]       bit_num,
    output logic             illegal,
    output logic             cycle_start
);

    typedef struct packed {
        logic [1:0]             phase;
        core_decode_pkg::seq_t  seq;
        logic [1:0]             cycles_left;
        logic [13:0]            iword;
        logic [7:0]             wreg;
        logic                   zero;
        logic                   carry;
        logic                   status_wr;
        logic                   file_wr;
        logic [7:0]             file_wdata;
        logic [1:0]             fmt;
        logic                   illegal;
        logic [2:0]             bit_num;
    } state_t;

    state_t cur;
    state_t next_cur;

    // ============================================================
    // Decode of the held word
    logic       is_or;
    logic       is_lsl;
    logic       is_two;
    logic       is_legal;
    logic       byte_op;
    logic       file_target;
    logic       ind_extra;
    logic [1:0] base_cycles;
    logic [7:0] alu_res;
    logic       alu_c;
    logic       writes_status;

    always_comb begin
        is_or  = (cur.iword[13:8] == `OP_OR_PAT);
        is_lsl = (cur.iword[13:8] == `OP_SHL_PAT);
        // Subroutine entries, exits, jumps and skips
        is_two = (cur.iword[13:11] == `OP_CALL_TOP)
            || (cur.iword[13:11] == `OP_JUMP_TOP)
            || (cur.iword == `OP_RETURN_WORD)
            || (cur.iword == `OP_INT_EXIT_WORD)
            || (cur.iword == `OP_CALC_CALL_WORD)
            || (cur.iword == `OP_OFS_JUMP_WORD)
            || (cur.iword[13:8] == `OP_LIT_EXIT_TOP)
            || (cur.iword[13:9] == `OP_REL_JUMP_TOP)
            || (cur.iword[13:10] == `OP_BITSKIP_CLR)
            || (cur.iword[13:10] == `OP_BITSKIP_SET)
            || (cur.iword[13:8] == `OP_DEC_SKIP_PAT)
            || (cur.iword[13:8] == `OP_INC_SKIP_PAT);
        // Top bits are compared, plus bits 6:4 when bits 13:7 are all clear
        is_legal = (cur.iword[13:12] != 2'h3)
            || (cur.iword[13:9] != 5'h1f)
            || (cur.iword[13:8] <= `OP_SHR_PAT);
        is_legal = is_legal && !((cur.iword[13:12] == 2'h0)
            && (cur.iword[11:7] == 5'h00) && (cur.iword[6:4] == 3'h5));
        // Control words share top bits with byte ops but name no file
        byte_op = ((cur.iword[13:12] == 2'h0) && (cur.iword[11:7] != 5'h00))
            || is_lsl || (cur.iword[13:8] == `OP_SHR_PAT);
        // Bit ops touch a file register too, skips included
        file_target = byte_op || (cur.iword[13:12] == 2'h1);
        ind_extra = file_target && indirect_sel && ptr_in_prog;
        base_cycles = 2'h1;
        if (is_two) begin
            base_cycles = 2'h2;
        end
        // Left shift with zero fill and bit 7 into carry, or inclusive OR
        alu_c = cur.carry;
        writes_status = 1'b0;
        alu_res = file_rdata;
        if (is_or) begin
            alu_res = cur.wreg | file_rdata;
            writes_status = 1'b1;
        end else if (is_lsl) begin
            alu_res = {file_rdata[6:0], 1'b0};
            alu_c = file_rdata[7];
            writes_status = 1'b1;
        end
    end

    // ============================================================
    // Sequencer
    always_comb begin
        next_cur = cur;
        next_cur.file_wr = 1'b0;
        next_cur.status_wr = 1'b0;
        next_cur.phase = cur.phase + 2'h1;
        if (cur.phase == `PHASE_LAST) begin
            unique case (cur.seq)
                core_decode_pkg::st_fetch: begin
                    next_cur.iword = prog_word;
                    next_cur.seq = core_decode_pkg::st_exec;
                end
                core_decode_pkg::st_exec, core_decode_pkg::st_extra: begin
                    if (cur.cycles_left > 2'h1) begin
                        next_cur.cycles_left = cur.cycles_left - 2'h1;
                        next_cur.seq = core_decode_pkg::st_extra;
                    end else begin
                        next_cur.iword = prog_word;
                        next_cur.seq = core_decode_pkg::st_exec;
                    end
                end
            endcase
        end
        // Capture decode when a new word becomes current
        if (cur.phase == 2'h0 && cur.seq == core_decode_pkg::st_exec) begin
            next_cur.cycles_left = base_cycles;
            if (ind_extra) begin
                next_cur.cycles_left = base_cycles + 2'h1;
            end
            next_cur.illegal = !is_legal;
            next_cur.bit_num = cur.iword[`B_NUM_HI:`B_NUM_LO];
            if (cur.iword[13:12] == 2'h1) begin
                next_cur.fmt = core_decode_pkg::fmt_bit;
            end else if (byte_op) begin
                next_cur.fmt = core_decode_pkg::fmt_byte;
            end else begin
                next_cur.fmt = core_decode_pkg::fmt_literal;
            end
        end
        // Read in phase 1, write result in phase 2
        if (cur.phase == 2'h1 && cur.seq == core_decode_pkg::st_exec
            && (is_or || is_lsl)) begin
            if (cur.iword[`D_BIT_POS]) begin
                next_cur.file_wr = 1'b1;
                next_cur.file_wdata = alu_res;
            end else begin
                next_cur.wreg = alu_res;
            end
            next_cur.zero = (alu_res == 8'h00);
            next_cur.status_wr = writes_status;
            if (is_lsl) begin
                next_cur.carry = alu_c;
            end else begin
                next_cur.carry = carry_in;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur <= '{phase: 2'h0, seq: core_decode_pkg::st_fetch, cycles_left: 2'h1,
                     iword: `IWORD_RESET, wreg: `WREG_RESET, zero: 1'b0, carry: 1'b0,
                     status_wr: 1'b0, file_wr: 1'b0, file_wdata: 8'h00, fmt: 2'h0,
                     illegal: 1'b0, bit_num: 3'h0};
        end else begin
            cur <= next_cur;
        end
    end

    // ============================================================
    // Outputs
    logic fetching;

    always_comb begin
        fetching = (cur.phase == `PHASE_LAST)
            && ((cur.seq == core_decode_pkg::st_fetch) || (cur.cycles_left <= 2'h1));
    end

    assign fetch_req   = fetching;
    assign file_addr   = cur.iword[`F_ADDR_HI:0];
    // Read also happens when the result only goes to the file
    assign file_rd     = (cur.phase == 2'h1) && (cur.seq == core_decode_pkg::st_exec)
                         && (is_or || is_lsl);
    assign file_wr     = cur.file_wr;
    assign file_wdata  = cur.file_wdata;
    assign zero_flag   = cur.zero;
    assign carry_flag  = cur.carry;
    assign status_wr   = cur.status_wr;
    assign wreg        = cur.wreg;
    assign fmt         = cur.fmt;
    assign bit_num     = cur.bit_num;
    assign illegal     = cur.illegal;
    assign cycle_start = (cur.phase == 2'h0);

    // ============================================================
    // Checks
    sequence s_read;
        file_rd && cur.iword[`D_BIT_POS];
    endsequence

    property p_cycle_len;
        @(posedge mclk) disable iff (rst) cycle_start |=> !cycle_start [*3] ##1 cycle_start;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle not four clocks");

    property p_rmw;
        @(posedge mclk) disable iff (rst) s_read |=> file_wr;
    endproperty
    a_rmw: assert property (p_rmw) else $error("write did not follow read");

    property p_wr_needs_rd;
        @(posedge mclk) disable iff (rst) file_wr |-> $past(file_rd);
    endproperty
    a_wr_needs_rd: assert property (p_wr_needs_rd) else $error("write without read");

    property p_zero;
        @(posedge mclk) disable iff (rst) status_wr |-> (zero_flag == (
            cur.iword[`D_BIT_POS] ? file_wdata == 8'h00 : wreg == 8'h00));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag mismatch");

    property p_lsl;
        @(posedge mclk) disable iff (rst) file_rd && is_lsl && cur.iword[`D_BIT_POS]
            |=> file_wdata == {$past(file_rdata[6:0]), 1'b0} && carry_flag == $past(file_rdata[7]);
    endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong");

    property p_or;
        @(posedge mclk) disable iff (rst) file_rd && is_or && !cur.iword[`D_BIT_POS]
            |=> wreg == ($past(wreg) | $past(file_rdata)) && carry_flag == $past(carry_in);
    endproperty
    a_or: assert property (p_or) else $error("or result wrong");

    property p_two;
        @(posedge mclk) disable iff (rst) cycle_start && cur.seq == core_decode_pkg::st_exec
            && is_two && !(file_target && indirect_sel && ptr_in_prog) |-> !fetch_req [*4];
    endproperty
    a_two: assert property (p_two) else $error("two-cycle op ended early");

    property p_dest_w;
        @(posedge mclk) disable iff (rst) file_rd && !cur.iword[`D_BIT_POS] |=> !file_wr;
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("file written for W target");

    // Lengths counted from the first phase of a new word to its next fetch
    sequence s_one_cycle;
        !fetch_req [*3] ##1 fetch_req;
    endsequence

    sequence s_two_cycles;
        !fetch_req [*7] ##1 fetch_req;
    endsequence

    sequence s_three_cycles;
        !fetch_req [*8] ##1 !fetch_req [*3] ##1 fetch_req;
    endsequence

    property p_one;
        @(posedge mclk) disable iff (rst) cycle_start && cur.seq == core_decode_pkg::st_exec
            && !is_two && !ind_extra |-> s_one_cycle;
    endproperty
    a_one: assert property (p_one) else $error("single-cycle op wrong length");

    property p_two_end;
        @(posedge mclk) disable iff (rst) cycle_start && cur.seq == core_decode_pkg::st_exec
            && is_two && !ind_extra |-> s_two_cycles;
    endproperty
    a_two_end: assert property (p_two_end) else $error("two-cycle op wrong length");

    property p_ind_one;
        @(posedge mclk) disable iff (rst) cycle_start && cur.seq == core_decode_pkg::st_exec
            && !is_two && ind_extra |-> s_two_cycles;
    endproperty
    a_ind_one: assert property (p_ind_one) else $error("indirect cycle missing");

    property p_ind_two;
        @(posedge mclk) disable iff (rst) cycle_start && cur.seq == core_decode_pkg::st_exec
            && is_two && ind_extra |-> s_three_cycles;
    endproperty
    a_ind_two: assert property (p_ind_two) else $error("indirect branch length wrong");

endmodule

/* File: tb_core_instruction_timing_decode.sv */
/*
 * Self-checking bench for the instruction decode and timing block.
 * Assumes the design holds its own assertions and that words are taken
 * at the edge where fetch_req is high.
 */
`timescale 1ns/10ps
module tb_core_instruction_timing_decode;

    // ============================================================
    // Signals
    typedef struct packed {
        logic [13:0] w;
        logic        ind;
        logic        ptr;
        logic        c;
        logic [7:0]  fv;
    } ins_t;

    logic        mclk         = 1'b0;
    logic        rst          = 1'b1;
    logic [13:0] prog_word    = 14'h0000;
    logic [7:0]  file_rdata   = 8'h00;
    logic        indirect_sel = 1'b0;
    logic        ptr_in_prog  = 1'b0;
    logic        carry_in     = 1'b0;
    logic        fetch_req;
    logic [6:0]  file_addr;
    logic        file_rd;
    logic        file_wr;
    logic [7:0]  file_wdata;
    logic        zero_flag;
    logic        carry_flag;
    logic        status_wr;
    logic [7:0]  wreg;
    logic [1:0]  fmt;
    logic [2:0]  bit_num;
    logic        illegal;
    logic        cycle_start;
    int          n_errors     = 0;
    int          checks       = 0;
    logic [15:0] seed         = 16'h3fd5;
    logic [7:0]  exp_w        = 8'h00;
    logic        primed       = 1'b0;
    ins_t        fl           = '0;
    ins_t        pn           = '0;

    always #50 mclk = ~mclk;

    core_instruction_timing_decode dut (
        .mclk(mclk), .rst(rst), .prog_word(prog_word), .fetch_req(fetch_req),
        .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata),
        .file_wr(file_wr), .file_wdata(file_wdata), .indirect_sel(indirect_sel),
        .ptr_in_prog(ptr_in_prog), .carry_in(carry_in), .zero_flag(zero_flag),
        .carry_flag(carry_flag), .status_wr(status_wr), .wreg(wreg), .fmt(fmt),
        .bit_num(bit_num), .illegal(illegal), .cycle_start(cycle_start)
    );

    // ============================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [13:0] mk(input int k, input logic [15:0] r);
        case (k)
            0: return {6'h04, r[7:0]};
            1: return {6'h35, r[7:0]};
            2: return {6'h0b, r[7:0]};
            3: return {6'h0f, r[7:0]};
            4: return {4'h6, r[9:0]};
            5: return {4'h7, r[9:0]};
            6: return {3'h4, r[10:0]};
            7: return {3'h5, r[10:0]};
            8: return {5'h19, r[8:0]};
            9: return {6'h34, r[7:0]};
            10: return 14'h0008;
            11: return 14'h0009;
            12: return 14'h000a;
            13: return 14'h000b;
            default: return 14'h0000;
        endcase
    endfunction

    function automatic ins_t pack(input logic [13:0] w, input logic [15:0] s);
        return '{w: w, ind: s[15], ptr: s[14], c: s[13], fv: s[7:0]};
    endfunction

    function automatic int cycles(input ins_t i);
        logic [13:0] w;
        int          n;
        logic        ft;
        w = i.w;
        n = 1;
        // Every op the bench issues that names a file register pays the indirect penalty
        ft = (w[13:12] == 2'h1) || (w[13:12] == 2'h0 && w[11:7] != 5'h00)
            || (w[13:8] == 6'h35);
        if (w[13:12] == 2'h2 || w[13:9] == 5'h19 || w[13:8] == 6'h34) n = 2;
        if (w[13:10] == 4'h6 || w[13:10] == 4'h7) n = 2;
        if (w[13:8] == 6'h0b || w[13:8] == 6'h0f) n = 2;
        if (w >= 14'h0008 && w <= 14'h000b) n = 2;
        return n + int'(ft & i.ind & i.ptr);
    endfunction

    function automatic logic [1:0] fmt_of(input logic [13:0] w);
        if (w[13:12] == 2'h1) return 2'h1;
        if (w[13:8] == 6'h04 || w[13:8] == 6'h35) return 2'h0;
        if (w[13:8] == 6'h0b || w[13:8] == 6'h0f) return 2'h0;
        return 2'h2;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ============================================================
    // One instruction: close the one in flight, present the next
    task automatic step(input ins_t nx);
        int         n;
        int         rd_n;
        int         wr_n;
        int         st_n;
        logic [7:0] wd;
        logic [7:0] r;
        logic       alu;
        n = 0;
        rd_n = 0;
        wr_n = 0;
        st_n = 0;
        wd = 8'h00;
        do begin
            @(posedge mclk);
            n++;
            if (file_rd === 1'b1) rd_n++;
            if (file_wr === 1'b1) begin
                wr_n++;
                wd = file_wdata;
            end
            if (status_wr === 1'b1) st_n++;
        end while (fetch_req !== 1'b1 && n < 64);
        alu = (fl.w[13:8] == 6'h04) || (fl.w[13:8] == 6'h35);
        r = (fl.w[13:8] == 6'h04) ? (exp_w | fl.fv) : {fl.fv[6:0], 1'b0};
        if (alu && !fl.w[7]) exp_w = r;
        chk(n, 4 * cycles(fl));
        if (primed) begin
            chk(rd_n, 32'(alu));
            chk(wr_n, 32'(alu & fl.w[7]));
            chk(st_n, 32'(alu));
            chk(wreg, exp_w);
            chk(fmt, fmt_of(fl.w));
            chk(illegal, 1'b0);
            if (fl.w[13:12] == 2'h1) chk(bit_num, fl.w[9:7]);
            if (alu) begin
                chk(zero_flag, 32'(r == 8'h00));
                chk(file_addr, fl.w[6:0]);
                if (fl.w[7]) chk(wd, r);
                if (fl.w[13:8] == 6'h35) chk(carry_flag, fl.fv[7]);
                else chk(carry_flag, fl.c);
            end
        end
        primed = 1'b1;
        fl = pn;
        pn = nx;
        prog_word <= nx.w;
        file_rdata <= fl.fv;
        indirect_sel <= fl.ind;
        ptr_in_prog <= fl.ptr;
        carry_in <= fl.c;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        int          k;
        logic [13:0] w;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (k = 0; k < 15; k++) begin
            seed = lfsr(seed);
            w = mk(k, seed);
            seed = lfsr(seed);
            step(pack(w, seed));
        end
        // Boundary addresses, zero results and the extra indirect cycle
        step('{{6'h04, 8'hff}, 1'b1, 1'b1, 1'b1, 8'h00});
        step('{{6'h35, 8'h00}, 1'b1, 1'b0, 1'b0, 8'h80});
        step('{{6'h35, 8'h7f}, 1'b0, 1'b1, 1'b1, 8'h41});
        step('{{6'h04, 8'h00}, 1'b0, 1'b0, 1'b0, 8'h00});
        step('{{6'h35, 8'hff}, 1'b1, 1'b1, 1'b0, 8'hc3});
        for (k = 0; k < 200; k++) begin
            seed = lfsr(seed);
            w = mk(int'(seed % 16'h000f), lfsr(seed));
            seed = lfsr(lfsr(seed));
            step(pack(w, seed));
        end
        // Flush the pipeline of presented words
        step(pack(14'h0000, 16'h0000));
        step(pack(14'h0000, 16'h0000));
        report_and_stop();
    end

    // ============================================================
    // Watchdog, about twice the longest expected run
    initial begin
        #600000;
        n_errors++;
        report_and_stop();
    end

endmodule
